// ---- design/nepc_map.vh ----
// nepc_map.vh: command codes, status bit positions and timing counts for the
// host-side nand erase/protect/status controller.
// assumes a 100 MHz core clock; included by bare name.
`ifndef NEPC_MAP_VH
`define NEPC_MAP_VH

// ****************************************
// command codes
// ****************************************
`define NEPC_CMD_READ1        8'h00
`define NEPC_CMD_READ3        8'h50
`define NEPC_CMD_ERASE_SETUP  8'h60
`define NEPC_CMD_ERASE_GO     8'hd0
`define NEPC_CMD_PROT_BASE    8'h40
`define NEPC_CMD_PROT_LOAD    8'h80
`define NEPC_CMD_PROT_GO      8'h10
`define NEPC_CMD_BLK_STATUS   8'h7a
`define NEPC_CMD_STATUS       8'h70
`define NEPC_CMD_READ_ID      8'h90
`define NEPC_CMD_RESET        8'hff
`define NEPC_ID_ADDR          8'h00

// ****************************************
// status bits and values
// ****************************************
`define NEPC_ST_FAIL_BIT      0
`define NEPC_ST_PPROT_BIT     0
`define NEPC_ST_EPROT_BIT     1
`define NEPC_ST_READY_BIT     6
`define NEPC_ST_WPN_BIT       7
`define NEPC_ST_RESET_VAL     8'hc0
`define NEPC_STAT_MASK        8'hc3

// ****************************************
// block addressing
// ****************************************
`define NEPC_BLK_LSB          14
`define NEPC_BLK_W            13
`define NEPC_PROT_MAX_BLK     13'd199
`define NEPC_ID_BYTES         4

// ****************************************
// timing
// ****************************************
`define NEPC_CLK_MHZ          100
`define NEPC_PWRUP_US         100
`define NEPC_PWRUP_CYC        (`NEPC_PWRUP_US * `NEPC_CLK_MHZ)
`define NEPC_STROBE_CYC       3

`endif

// ---- design/nepc_sync.v ----
// nepc_sync.v: two-flop synchroniser for a level coming in from a pin.
// assumes the input is asynchronous to core_clk; first flop read only by the second.
`timescale 1ns/1ps
`default_nettype none

module nepc_sync #(
   parameter W = 1
) (
   // clock and reset
   input  wire         core_clk,
   input  wire         rst,
   // level in and out
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);

   reg [W-1:0] meta_reg;

   always @(posedge core_clk) begin
      if (rst) begin
         meta_reg <= {W{1'b0}};
         dout     <= {W{1'b0}};
      end else begin
         meta_reg <= din;
         dout     <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// ---- design/nepc_host.v ----
// nepc_host.v: host controller driving a small-page nand through its pins
// for block erase, block protect, status reads, id readout and reset.
// assumes the flash pins are wired to the bench; ready/busy is pulled up.
`timescale 1ns/1ps
`default_nettype none
`include "nepc_map.vh"

module nepc_host #(
   parameter PWRUP_CYC  = `NEPC_PWRUP_CYC,
   parameter STROBE_CYC = `NEPC_STROBE_CYC
) (
   // clock and reset
   input  wire        core_clk,
   input  wire        rst,
   // user command port
   input  wire        op_valid,
   input  wire [2:0]  op_code,
   input  wire [12:0] op_block,
   input  wire [1:0]  op_prot_kind,
   input  wire        op_wp_n,
   output reg         op_ready,
   output reg         op_done,
   output reg  [7:0]  op_status,
   output reg  [31:0] op_id,
   output reg         op_refused,
   // flash pins
   output reg         ce_n,
   output reg         cle,
   output reg         ale,
   output reg         we_n,
   output reg         read_strobe_n,
   output reg         wp_n,
   output reg  [7:0]  io_out,
   output reg         io_oe,
   input  wire [7:0]  io_in,
   input  wire        rb_in,
   output reg         rb_out,
   output reg         rb_oe
);

   // op codes
   localparam OP_ERASE   = 3'd0;
   localparam OP_PROTECT = 3'd1;
   localparam OP_STATUS  = 3'd2;
   localparam OP_BLKSTAT = 3'd3;
   localparam OP_READID  = 3'd4;
   localparam OP_RESET   = 3'd5;
   localparam OP_WP      = 3'd6;

   // states
   localparam S_PWRUP = 4'd0;
   localparam S_IDLE  = 4'd1;
   localparam S_WR    = 4'd2;
   localparam S_WAITB = 4'd3;
   localparam S_BUSY  = 4'd4;
   localparam S_RD    = 4'd5;
   localparam S_DONE  = 4'd6;

   // ****************************************
   // pin synchronisers
   // ****************************************
   wire [7:0] io_s;
   wire       rb_s;

   nepc_sync #(.W(9)) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .din      ({rb_in, io_in}),
      .dout     ({rb_s, io_s})
   );

   // ****************************************
   // sequencer
   // ****************************************
   reg [3:0]  state_reg;
   reg [16:0] cnt_reg;
   reg [2:0]  idx_reg;
   reg [2:0]  op_reg;
   reg [12:0] blk_reg;
   reg [1:0]  kind_reg;
   reg [2:0]  rd_left_reg;

   // byte sequence for the current op: {cle, ale, byte}, last flag
   reg [9:0] seq_word;
   reg       seq_last;
   wire [26:0] blk_addr = {blk_reg, 14'h0000};  // low bits zero

   always @* begin
      seq_word = {2'b10, `NEPC_CMD_RESET};
      seq_last = 1'b1;
      case (op_reg)
         OP_ERASE: begin
            case (idx_reg)
               3'd0: seq_word = {2'b10, `NEPC_CMD_ERASE_SETUP};
               3'd1: seq_word = {2'b01, blk_addr[16:9]};
               3'd2: seq_word = {2'b01, blk_addr[24:17]};
               3'd3: seq_word = {2'b01, 6'h00, blk_addr[26:25]};
               default: seq_word = {2'b10, `NEPC_CMD_ERASE_GO};
            endcase
            seq_last = (idx_reg == 3'd4);
         end
         OP_PROTECT: begin
            case (idx_reg)
               3'd0: seq_word = {2'b10, `NEPC_CMD_PROT_BASE | {6'h00, kind_reg}};
               3'd1: seq_word = {2'b10, `NEPC_CMD_PROT_LOAD};
               3'd2: seq_word = {2'b01, blk_addr[7:0]};
               3'd3: seq_word = {2'b01, blk_addr[16:9]};
               3'd4: seq_word = {2'b01, blk_addr[24:17]};
               3'd5: seq_word = {2'b01, 6'h00, blk_addr[26:25]};
               default: seq_word = {2'b10, `NEPC_CMD_PROT_GO};
            endcase
            seq_last = (idx_reg == 3'd6);
         end
         OP_STATUS: seq_word = {2'b10, `NEPC_CMD_STATUS};
         OP_BLKSTAT: begin  // block status needs the block address
            case (idx_reg)
               3'd0: seq_word = {2'b10, `NEPC_CMD_BLK_STATUS};
               3'd1: seq_word = {2'b01, blk_addr[7:0]};
               3'd2: seq_word = {2'b01, blk_addr[16:9]};
               3'd3: seq_word = {2'b01, blk_addr[24:17]};
               default: seq_word = {2'b01, 6'h00, blk_addr[26:25]};
            endcase
            seq_last = (idx_reg == 3'd4);
         end
         OP_READID: begin
            seq_word = (idx_reg == 3'd0) ? {2'b10, `NEPC_CMD_READ_ID}
                                         : {2'b01, `NEPC_ID_ADDR};
            seq_last = (idx_reg == 3'd1);
         end
         default: seq_word = {2'b10, `NEPC_CMD_RESET};
      endcase
   end

   wire bad_prot = (op_code == OP_PROTECT) &&
                   ((op_block > `NEPC_PROT_MAX_BLK) || (op_prot_kind == 2'd0));
   wire is_busy_op = (op_reg == OP_ERASE) || (op_reg == OP_PROTECT) ||
                     (op_reg == OP_RESET);
   wire [16:0] strobe_n = STROBE_CYC[16:0];

   always @(posedge core_clk) begin
      if (rst) begin
         state_reg     <= S_PWRUP;
         cnt_reg       <= 17'h00000;
         idx_reg       <= 3'd0;
         op_reg        <= OP_RESET;
         blk_reg       <= 13'h0000;
         kind_reg      <= 2'd0;
         rd_left_reg   <= 3'd0;
         op_ready      <= 1'b0;
         op_done       <= 1'b0;
         op_status     <= 8'h00;
         op_id         <= 32'h00000000;
         op_refused    <= 1'b0;
         ce_n          <= 1'b1;
         cle           <= 1'b0;
         ale           <= 1'b0;
         we_n          <= 1'b1;
         read_strobe_n <= 1'b1;
         wp_n          <= 1'b0;  // protected through power-up
         io_out        <= 8'h00;
         io_oe         <= 1'b0;
         rb_out        <= 1'b0;
         rb_oe         <= 1'b0;  // host never drives ready/busy
      end else begin
         op_done    <= 1'b0;
         op_refused <= 1'b0;
         case (state_reg)
            S_PWRUP: begin
               cnt_reg <= cnt_reg + 17'd1;
               if (cnt_reg == PWRUP_CYC[16:0] - 17'd1) begin
                  state_reg <= S_IDLE;
                  op_ready  <= 1'b1;
               end
            end
            S_IDLE: begin
               if (op_valid) begin
                  op_ready <= 1'b0;
                  if (bad_prot) begin
                     op_refused <= 1'b1;
                     op_done    <= 1'b1;
                     state_reg  <= S_DONE;
                  end else if (op_code == OP_WP) begin
                     wp_n      <= op_wp_n;  // only while idle
                     op_done   <= 1'b1;
                     state_reg <= S_DONE;
                  end else begin
                     op_reg    <= op_code;
                     blk_reg   <= op_block;
                     kind_reg  <= op_prot_kind;
                     idx_reg   <= 3'd0;
                     cnt_reg   <= 17'h00000;
                     ce_n      <= 1'b0;
                     state_reg <= S_WR;
                  end
               end
            end
            S_WR: begin
               // phase: setup lines, drop we_n, raise we_n (latch on rise)
               cnt_reg <= cnt_reg + 17'd1;
               if (cnt_reg == 17'd0) begin
                  cle    <= seq_word[9];
                  ale    <= seq_word[8];
                  io_out <= seq_word[7:0];
                  io_oe  <= 1'b1;
               end else if (cnt_reg == 17'd1) begin
                  we_n <= 1'b0;
               end else if (cnt_reg == strobe_n) begin
                  we_n <= 1'b1;
               end else if (cnt_reg == strobe_n + 17'd1) begin
                  cle     <= 1'b0;
                  ale     <= 1'b0;
                  io_oe   <= 1'b0;
                  cnt_reg <= 17'h00000;
                  idx_reg <= idx_reg + 3'd1;
                  if (seq_last)
                     state_reg <= is_busy_op ? S_WAITB : S_RD;
               end
            end
            S_WAITB: begin
               // give the device time to pull ready/busy low
               cnt_reg <= cnt_reg + 17'd1;
               if (cnt_reg == strobe_n + 17'd2) begin
                  cnt_reg   <= 17'h00000;
                  state_reg <= S_BUSY;
               end
            end
            S_BUSY: begin
               // only status polls and reset are legal now; the host simply waits
               if (rb_s) begin
                  cnt_reg     <= 17'h00000;
                  if (op_reg == OP_RESET) begin
                     state_reg <= S_DONE;
                     op_done   <= 1'b1;
                     ce_n      <= 1'b1;
                  end else begin
                     // fetch pass/fail so a refused op is reported
                     op_reg      <= OP_STATUS;
                     idx_reg     <= 3'd0;
                     state_reg   <= S_WR;
                  end
               end
            end
            S_RD: begin
               cnt_reg <= cnt_reg + 17'd1;
               if (cnt_reg == 17'd0) begin
                  read_strobe_n <= 1'b0;
               end else if (cnt_reg == strobe_n + 17'd2) begin
                  // sampled after the two-flop delay; level stays valid
                  read_strobe_n <= 1'b1;
                  cnt_reg       <= 17'h00000;
                  if (op_reg == OP_READID) begin
                     op_id       <= {op_id[23:0], io_s};
                     rd_left_reg <= rd_left_reg + 3'd1;
                     if (rd_left_reg == 3'd`NEPC_ID_BYTES - 3'd1) begin
                        rd_left_reg <= 3'd0;
                        state_reg   <= S_DONE;
                        op_done     <= 1'b1;
                        ce_n        <= 1'b1;
                     end
                  end else begin
                     op_status <= io_s & `NEPC_STAT_MASK;
                     op_refused <= io_s[`NEPC_ST_FAIL_BIT] &&
                                   (op_reg == OP_STATUS);
                     state_reg <= S_DONE;
                     op_done   <= 1'b1;
                     ce_n      <= 1'b1;
                  end
               end
            end
            S_DONE: begin
               // device remains in the mode of its last command (status, block status, id or reset); a new op sends its own command,
               op_ready  <= 1'b1;
               state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

endmodule

`default_nettype wire

// ---- dv/nepc_host_sva.sv ----
// nepc_host_sva.sv: checker on the host controller's user port and flash pins.
// assumes one clock domain, core_clk, with synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module nepc_host_sva #(
   parameter PWRUP_CYC  = 10000,
   parameter STROBE_CYC = 3
) (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // user port
   input wire logic        op_valid,
   input wire logic [2:0]  op_code,
   input wire logic [12:0] op_block,
   input wire logic [1:0]  op_prot_kind,
   input wire logic        op_ready,
   input wire logic        op_done,
   input wire logic [7:0]  op_status,
   input wire logic        op_refused,
   // flash pins
   input wire logic        ce_n,
   input wire logic        cle,
   input wire logic        ale,
   input wire logic        we_n,
   input wire logic        read_strobe_n,
   input wire logic        wp_n,
   input wire logic [7:0]  io_out,
   input wire logic        io_oe,
   input wire logic        rb_out,
   input wire logic        rb_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // ****************************************
   // assertions
   // ****************************************
   logic [15:0] up_cnt;
   always_ff @(posedge core_clk) begin
      if (rst) up_cnt <= 16'h0000;
      else if (up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h0001;
   end
   powerup_wait_a: assert property (op_ready |-> up_cnt >= PWRUP_CYC)
      else $error("ready before power-up wait");
   prot_refuse_a: assert property (op_valid && op_ready && op_code == 3'd1 &&
      (op_prot_kind == 2'd0 || op_block > 13'd199) |=>
      (ce_n throughout ##[0:2] (op_done && op_refused)))
      else $error("bad protect request not refused");
   refuse_pair_a: assert property (op_refused |-> op_done)
      else $error("refusal without done");
   one_op_a: assert property (op_valid && op_ready |=> !op_ready)
      else $error("second request open during operation");
   done_pulse_a: assert property (op_done |-> !op_ready ##1 (!op_done && op_ready))
      else $error("done not a single pulse");
   byte_hold_a: assert property (!we_n && $past(!we_n) |->
      $stable(io_out) && $stable(cle) && $stable(ale) && io_oe)
      else $error("byte moved while latched");
   latch_edge_a: assert property ($rose(we_n) |-> io_oe && (cle || ale) && !ce_n)
      else $error("write strobe rose without a byte");
   read_clear_a: assert property (!read_strobe_n |-> !io_oe && we_n && !cle && !ale)
      else $error("io driven during read");
   status_mask_a: assert property (op_done |-> (op_status & 8'h3c) == 8'h00)
      else $error("unused status bits kept");
   rb_free_a: assert property (!(rb_oe && !rb_out))
      else $error("host pulls ready/busy low");
   wp_idle_a: assert property ($changed(wp_n) |->
      $past(op_ready) || $past(op_ready, 2))
      else $error("write protect moved during work");
   cover property (op_done && op_refused);
   cover property ($rose(we_n) && cle);
   cover property (op_valid && op_ready && op_code == 3'd4);
   cover property (op_valid && op_ready && op_code == 3'd0);
endmodule
bind nepc_host nepc_host_sva #(.PWRUP_CYC(PWRUP_CYC), .STROBE_CYC(STROBE_CYC)) u_sva (
   .core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .op_block(op_block),
   .op_prot_kind(op_prot_kind), .op_ready(op_ready), .op_done(op_done), .op_status(op_status),
   .op_refused(op_refused), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
   .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe),
   .rb_out(rb_out), .rb_oe(rb_oe));
`default_nettype wire

// ---- dv/nepc_flash_model.sv ----
// nepc_flash_model.sv: behavioural small-page nand at its pins: erase, protect,
// status reads, id and reset. assumes the bench resolves io and pulls ready/busy up.
`timescale 1ns/1ps
`default_nettype none
module nepc_flash_model #(
   parameter [31:0] ID_BYTES = 32'h11223344,
   parameter        LOAD_NS  = 300,
   parameter        ERASE_NS = 2000,
   parameter        PROG_NS  = 1500,
   parameter        RST_NS   = 400
) (
   // flash pins
   input  wire logic       ce_n,
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       we_n,
   input  wire logic       read_strobe_n,
   input  wire logic       wp_n,
   input  wire logic [7:0] din,
   output wire logic [7:0] dq,
   output var  logic       busy
);
   // ****************************************
   // command decoding
   // ****************************************
   logic [7:0]  cmd;
   logic [7:0]  pcode;
   logic [7:0]  st;
   logic [7:0]  q;
   logic [7:0]  last_q;
   logic [7:0]  ab [4];
   logic [1:0]  prot [8192];
   logic [2:0]  n;
   logic [2:0]  idx;
   logic [12:0] blk;
   logic [12:0] last_erase;
   time         busy_end;
   initial begin
      cmd = 8'h00;
      pcode = 8'h00;
      st = 8'h00;
      busy = 0;
      n = 0;
      idx = 0;
      last_q = 8'h00;
      last_erase = 0;
      foreach (prot[i]) prot[i] = 2'b00;
   end
   // block is always A14..A26, whatever the address count
   assign blk = (n == 3) ? {ab[2][1:0], ab[1], ab[0][7:5]}
                         : {ab[3][1:0], ab[2], ab[1][7:5]};
   task automatic go_busy(input time t);
      busy = 1;
      busy_end = $time + t;
   endtask
   always #5 if (busy && $time >= busy_end) busy = 0;
   always @(posedge we_n) begin
      if (!ce_n && cle && (!busy || din == 8'h70 || din == 8'hff)) begin
         cmd = din;
         case (din)
            8'hff: begin
               st = 8'h00;
               pcode = 8'h00;
               go_busy(RST_NS);
            end
            8'hd0: begin
               if (n == 3 && prot[blk][1]) begin
                  st = 8'h01;
                  go_busy(LOAD_NS);
               end else if (n == 3) begin
                  prot[blk] = 2'b00;
                  last_erase = blk;
                  st = 8'h00;
                  go_busy(ERASE_NS);
               end
            end
            8'h10: begin
               if (n == 4 && pcode[7:4] == 4'h4) begin
                  prot[blk] = pcode[1:0];
                  pcode = 8'h00;
                  st = 8'h00;
                  go_busy(PROG_NS);
               end else if (prot[blk][0]) begin
                  go_busy(LOAD_NS);
               end
            end
            default: begin
               n = 0;
               idx = 0;
               if (din != 8'h80)
                  pcode = (din[7:4] == 4'h4) ? din : 8'h00;
            end
         endcase
      end else if (!ce_n && ale && !busy) begin
         ab[n[1:0]] = din;
         n = n + 3'd1;
      end
   end
   always @* begin
      case (cmd)
         8'h70:   q = {wp_n, ~busy, 5'b00000, st[0]};
         8'h7a:   q = {wp_n, ~busy, 4'b0000, prot[blk]};
         8'h90:   q = ID_BYTES[31 - 8 * idx[1:0] -: 8];
         default: q = 8'h00;
      endcase
   end
   // status follows live while both strobes stay low; a released bus shows the stale inverse
   assign dq = (!ce_n && !read_strobe_n) ? q : ~last_q;
   always @(posedge read_strobe_n) begin
      last_q = q;
      idx = idx + 3'd1;
   end
endmodule
`default_nettype wire

// ---- dv/test_nand_erase_protect_status_ctrl.sv ----
// test_nand_erase_protect_status_ctrl.sv: bench for nepc_host against the flash model.
// assumes the design and the model are compiled first; ready/busy has a pull-up here.
`timescale 1ns/1ps
`default_nettype none
module test_nand_erase_protect_status_ctrl;
   localparam PW = 20;
   localparam [31:0] ID = 32'h5a173ce1; // arbitrary id values
   logic core_clk = 0, rst = 1, op_valid = 0, op_wp_n = 1;
   logic [2:0] op_code = 0;
   logic [12:0] op_block = 0;
   logic [1:0] op_prot_kind = 0;
   wire logic op_ready, op_done, op_refused, ce_n, cle, ale, we_n, rd_n;
   wire logic wp_n, io_oe, rb_out, rb_oe, busy;
   wire logic [7:0] op_status, io_out, dq;
   wire logic [31:0] op_id;
   wire logic [7:0] io_bus = io_oe ? io_out : dq;
   wire logic rb = !(busy || (rb_oe && !rb_out));
   int fails = 0, check_count = 0, t;
   nepc_host #(.PWRUP_CYC(PW)) DUT (.core_clk(core_clk), .rst(rst), .op_valid(op_valid),
      .op_code(op_code), .op_block(op_block), .op_prot_kind(op_prot_kind), .op_wp_n(op_wp_n),
      .op_ready(op_ready), .op_done(op_done), .op_status(op_status), .op_id(op_id),
      .op_refused(op_refused), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
      .read_strobe_n(rd_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_bus),
      .rb_in(rb), .rb_out(rb_out), .rb_oe(rb_oe));
   nepc_flash_model #(.ID_BYTES(ID)) model (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
      .read_strobe_n(rd_n), .wp_n(wp_n), .din(io_bus), .dq(dq), .busy(busy));
   initial forever #5 core_clk = ~core_clk;
   // ****************************************
   // access tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic run_op(input logic [2:0] c, input logic [12:0] b,
                         input logic [1:0] k, input logic w);
      int n;
      n = 0;
      while (op_ready !== 1'b1 && n < 2000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk(op_ready, 1, "ready before request");
      op_code = c;
      op_block = b;
      op_prot_kind = k;
      op_wp_n = w;
      op_valid = 1;
      @(posedge core_clk);
      #1 op_valid = 0;
      n = 0;
      while (op_done !== 1'b1 && n < 2000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk(n < 2000, 1, "operation finished");
   endtask
   task automatic close_out;
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #300us;
      fails++;
      $display("mismatch at %0t: watchdog expired", $time);
      close_out;
   end
   // ****************************************
   // test sequence
   // ****************************************
   initial begin
      repeat (10) @(posedge core_clk);
      #1 rst = 0;
      t = 0;
      while (op_ready !== 1'b1 && t < 500) begin
         @(posedge core_clk);
         #1;
         t++;
      end
      chk(op_ready === 1'b1 && t >= PW, 1, "power-up wait");
      run_op(6, 0, 0, 1);
      run_op(2, 0, 0, 1);
      chk(op_status, 8'hc0, "status at start");
      for (int k = 1; k < 4; k++) begin
         run_op(1, 13'd4 + k, k, 1);
         chk(op_refused, 0, "protect accepted");
         run_op(3, 13'd4 + k, 0, 1);
         chk(op_status, 8'hc0 | k, "block status");
      end
      run_op(0, 13'd6, 0, 1);
      chk(op_refused, 1, "locked erase refused");
      chk(op_status, 8'hc1, "fail bit on refusal");
      run_op(3, 13'd6, 0, 1);
      chk(op_status, 8'hc2, "locked block kept");
      run_op(0, 13'd5, 0, 1);
      chk(op_refused, 0, "program-locked erase");
      run_op(3, 13'd5, 0, 1);
      chk(op_status, 8'hc0, "flag erased");
      run_op(0, 13'h1abc, 0, 1);
      chk(model.last_erase, 13'h1abc, "erase block");
      run_op(1, 13'd200, 1, 1);
      chk(op_refused, 1, "protect past 200th");
      run_op(1, 13'd9, 0, 1);
      chk(op_refused, 1, "protect kind zero");
      run_op(4, 0, 0, 1);
      chk(op_id, ID, "id bytes");
      run_op(5, 0, 0, 1);
      chk(op_refused, 0, "reset done");
      run_op(2, 0, 0, 1);
      chk(op_status, 8'hc0, "status after reset");
      run_op(6, 0, 0, 0);
      run_op(2, 0, 0, 0);
      chk(op_status, 8'h40, "write protect bit");
      close_out;
   end
endmodule
`default_nettype wire
